// File: bench/code_mem_model.sv
// Behavioural asynchronous-read code memory facing the fetch port
module code_mem_model (
    // Clock
    input wire logic clk,
    // Fetch port
    input wire logic [15:0] code_addr,
    input wire logic code_rd,
    output logic [7:0] code_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:511]; // Program image, loaded by the bench
    logic [7:0] last = 8'h00; // Last byte handed over
    // Unread data shows the inverse of the last byte, never a stale copy
    always_comb begin
        code_data = code_rd ? mem[code_addr[8:0]] : ~last;
    end
    // Remember the byte taken at each fetch edge
    always @(posedge clk) begin
        if (code_rd) begin
            last <= code_data;
        end
    end
endmodule

// File: bench/cpu_fetch_exec_timing_tb.sv
// Self-checking bench for the fetch/execute timing block
module cpu_fetch_exec_timing_tb import fetch_timing_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Test program: one-byte, immediate, multiply, long jump
    localparam logic [7:0] PROG [7] = '{8'h04, 8'h74, 8'h55, 8'hA4, 8'h02, 8'h12, 8'h34};
    localparam logic [7:0] EXP_OP [4] = '{8'h04, 8'h74, 8'hA4, 8'h02};
    localparam logic [7:0] EXP_O1 [4] = '{8'h00, 8'h55, 8'h00, 8'h12};
    localparam logic [7:0] EXP_O2 [4] = '{8'h00, 8'h00, 8'h00, 8'h34};
    localparam int EXP_LEN [4] = '{1, 2, 1, 3};
    localparam int EXP_EXTRA [4] = '{0, 0, 2, 1};
    localparam int EXP_MC [4] = '{1, 1, 4, 2};
    logic clk, rst, compat_fuse, code_rd, redirect_valid, exec_valid;
    logic fast_mode, mode_ready, state_tick, code_external;
    logic [15:0] code_addr, redirect_addr;
    logic [7:0] code_data;
    logic [2:0] mc_state;
    instr_t exec_instr;
    int n_fail = 0, comparisons = 0, cyc = 0; // Counters
    int iss_t[$]; // Issue times
    instr_t iss_i[$]; // Issued instructions
    // Design with code from 0x100 up treated as external
    fetch_exec_timing #(.INTERNAL_CODE_SIZE(17'h00100)) dut_u (.clk(clk), .rst(rst),
        .compat_fuse(compat_fuse), .code_addr(code_addr), .code_rd(code_rd),
        .code_data(code_data), .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
        .exec_valid(exec_valid), .exec_instr(exec_instr), .fast_mode(fast_mode),
        .mode_ready(mode_ready), .state_tick(state_tick), .mc_state(mc_state),
        .code_external(code_external));
    code_mem_model mem_u (.clk(clk), .code_addr(code_addr), .code_rd(code_rd),
        .code_data(code_data));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycle count, timeout and issue capture
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (exec_valid === 1'b1) begin
            iss_t.push_back(cyc);
            iss_i.push_back(exec_instr);
        end
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Reset with a fuse level, then redirect to the program copy at base
    task automatic start_run(input logic fuse, input logic [15:0] base);
        @(posedge clk);
        compat_fuse <= fuse;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("reset mode", fast_mode, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 20 && mode_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check("fuse mode", fast_mode, !fuse);
        @(posedge clk);
        redirect_valid <= 1'b1;
        redirect_addr <= base;
        @(posedge clk);
        redirect_valid <= 1'b0;
        #1;
        iss_t.delete();
        iss_i.delete();
        for (int i = 0; i < 400 && iss_t.size() < 4; i++) begin
            @(posedge clk);
        end
        #1;
    endtask
    // Judge the four issues and their spacing
    task automatic check_issues(input bit compat, input int mult);
        int gap;
        check("issues", iss_t.size() >= 4, 1'b1);
        for (int k = 0; k < 4 && iss_t.size() >= 4; k++) begin
            check("opcode", iss_i[k].opcode, EXP_OP[k]);
            check("operand1", iss_i[k].op1, EXP_O1[k]);
            check("operand2", iss_i[k].op2, EXP_O2[k]);
            check("length", iss_i[k].len, EXP_LEN[k]);
            if (k > 0) begin
                gap = compat ? EXP_MC[k] * OSC_PER_MC : (EXP_LEN[k] + EXP_EXTRA[k]) * mult;
                check("spacing", iss_t[k] - iss_t[k-1], gap);
            end
        end
    endtask
    // Fast mode from internal code, then a fuse change that must be ignored
    task automatic scn_fast_int();
        start_run(1'b0, 16'h0000);
        check_issues(1'b0, 1);
        check("internal", code_external, 1'b0);
        @(posedge clk);
        compat_fuse <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check("held mode", fast_mode, 1'b1);
    endtask
    // Fast mode from external code runs three times slower
    task automatic scn_fast_ext();
        start_run(1'b0, 16'h0100);
        check("external", code_external, 1'b1);
        check_issues(1'b0, 3);
    endtask
    // Compatibility mode, internal then external code, same timing
    task automatic scn_compat();
        start_run(1'b1, 16'h0000);
        check_issues(1'b1, 1);
        start_run(1'b1, 16'h0100);
        check_issues(1'b1, 1);
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst <= 1'b1;
        compat_fuse <= 1'b1;
        redirect_valid <= 1'b0;
        redirect_addr <= 16'h0000;
        for (int i = 0; i < 512; i++) begin
            mem_u.mem[i] = 8'h04;
        end
        for (int i = 0; i < 7; i++) begin
            mem_u.mem[i] = PROG[i];
            mem_u.mem[256 + i] = PROG[i];
        end
        scn_fast_int();
        scn_fast_ext();
        scn_compat();
        end_of_test();
    end
endmodule

// File: bench/fetch_exec_timing_monitor.sv
// Assertion checker watching the ports of the fetch/execute timing block
module fetch_exec_timing_monitor
    import fetch_timing_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fuse and code port
    input wire logic compat_fuse,
    input wire logic [ADDR_W-1:0] code_addr,
    input wire logic code_rd,
    input wire logic [7:0] code_data,
    // Redirect from execute
    input wire logic redirect_valid,
    input wire logic [ADDR_W-1:0] redirect_addr,
    // Issue and status
    input wire logic exec_valid,
    input wire instr_t exec_instr,
    input wire logic fast_mode,
    input wire logic mode_ready,
    input wire logic state_tick,
    input wire logic [2:0] mc_state,
    input wire logic code_external
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Two fetch-free clocks, cut short only by a redirect
    sequence two_idle;
        !code_rd ##1 (!code_rd || $past(redirect_valid));
    endsequence
    // Eleven clocks without an issue
    sequence quiet11;
        !exec_valid [*8] ##1 !exec_valid [*3];
    endsequence
    AST_NO_EARLY_FETCH: assert property (!mode_ready |-> !code_rd)
        else $error("code fetch before mode capture");
    AST_MODE_FROM_FUSE: assert property ($rose(mode_ready) |-> fast_mode == (compat_fuse != FUSE_COMPAT))
        else $error("mode does not follow fuse");
    AST_MODE_HOLD: assert property (mode_ready |=> $stable(fast_mode))
        else $error("mode changed after capture");
    AST_TAKE_ADVANCE: assert property (code_rd && !redirect_valid |=> code_addr == $past(code_addr) + 1'b1)
        else $error("address did not step after a fetch");
    AST_FAST_OVERLAP: assert property (fast_mode && !code_external && exec_valid && !redirect_valid |-> code_rd)
        else $error("no fetch overlapping issue");
    AST_EXT_GAP: assert property (fast_mode && code_external && code_rd |=> two_idle)
        else $error("external fast fetch too close");
    AST_COMPAT_GAP: assert property (!fast_mode && code_rd |=> two_idle)
        else $error("compatibility fetch too close");
    AST_COMPAT_ISSUE_GAP: assert property (!fast_mode && exec_valid |=> quiet11)
        else $error("compatibility issue under twelve clocks");
    AST_HALF_RATE: assert property (state_tick && !redirect_valid |=> !state_tick)
        else $error("state advanced two clocks running");
    AST_STATE_STEP: assert property (state_tick && !redirect_valid |=>
        mc_state == (($past(mc_state) == 3'h5) ? 3'h0 : $past(mc_state) + 3'h1))
        else $error("machine state step wrong");
    AST_NO_TICK_FAST: assert property (fast_mode |-> !state_tick && mc_state <= 3'h5)
        else $error("state tick in fast mode");
    AST_LEN_RANGE: assert property (exec_valid |-> exec_instr.len != 2'h0 &&
        (exec_instr.len == LEN_3 || exec_instr.op2 == 8'h00))
        else $error("issued length or operand wrong");
endmodule
bind fetch_exec_timing fetch_exec_timing_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk(clk), .rst(rst),
    .compat_fuse(compat_fuse), .code_addr(code_addr), .code_rd(code_rd), .code_data(code_data),
    .redirect_valid(redirect_valid), .redirect_addr(redirect_addr), .exec_valid(exec_valid),
    .exec_instr(exec_instr), .fast_mode(fast_mode), .mode_ready(mode_ready),
    .state_tick(state_tick), .mc_state(mc_state), .code_external(code_external));

// File: verilog/fetch_exec_timing.sv
// Instruction fetch and execute timing control for the 8-bit core
module fetch_exec_timing
    import fetch_timing_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter logic [ADDR_W:0] INTERNAL_CODE_SIZE = 17'h10000,
    parameter logic [ADDR_W-1:0] RESET_PC = 16'h0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration fuse level
    input wire logic compat_fuse,
    // Code memory read port
    output logic [ADDR_W-1:0] code_addr,
    output logic code_rd,
    input wire logic [7:0] code_data,
    // Redirect from the execute stage
    input wire logic redirect_valid,
    input wire logic [ADDR_W-1:0] redirect_addr,
    // Instruction issue to the execute stage
    output logic exec_valid,
    output instr_t exec_instr,
    // Mode and machine-cycle status
    output logic fast_mode,
    output logic mode_ready,
    output logic state_tick,
    output logic [2:0] mc_state,
    output logic code_external
);

    // Sequencer states
    typedef enum logic [1:0] {S_INIT, S_FETCH, S_EXTRA, S_ALIGN} seq_t;

    logic fuse_meta; // First synchroniser stage
    logic fuse_sync; // Second synchroniser stage
    logic [1:0] init_cnt; // Waits for the synchroniser to fill
    core_mode_t mode; // Held mode
    seq_t state; // Sequencer state
    logic [ADDR_W-1:0] pc; // Next byte address
    logic [1:0] fetch_div; // Fetch slot divider
    logic slot; // A byte is fetched this clock
    logic [1:0] byte_idx; // Byte position inside the instruction
    decode_t dec_cur; // Decode of the held opcode
    decode_t dec_now; // Decode of the byte on the bus
    decode_t dec_use; // Decode that governs this slot
    logic [2:0] extra_cnt; // Remaining extra slots
    logic [MC_CLK_W-1:0] instr_clk; // Clocks since instruction start
    logic [MC_CLK_W-1:0] mc_end; // Last clock of the instruction
    logic last_byte; // This slot takes the final byte
    logic start; // Next clock begins a new instruction
    logic retire_fast; // Fast-mode completion this clock
    logic retire_compat; // Compatibility completion this clock
    logic extra_slot; // An extra cycle may elapse this clock
    logic half; // System clock divided by two
    instr_t hold; // Bytes gathered so far

    // Length, timing class and branch flag from the opcode
    function automatic decode_t decode_op(input logic [7:0] op);
        decode_t d;
        d.len = LEN_1;
        d.extra = EXTRA_NONE;
        d.mcyc = MC_SHORT;
        d.branch = 1'b0;
        // Three-byte forms
        if (op == 8'h02 || op == 8'h12 || op == 8'h10 || op == 8'h20 || op == 8'h30 ||
            op == 8'h43 || op == 8'h53 || op == 8'h63 || op == 8'h75 || op == 8'h85 ||
            op == 8'h90 || op == 8'hD5 || op[7:4] == 4'hB && op[3:2] != 2'h0) begin
            d.len = LEN_3;
        end else if (op[3:0] == 4'h1 || op[3:0] == 4'h0 && op[7:4] >= 4'h4 && op[7:4] <= 4'hD
                     || op[3:0] == 4'h2 && op[7:4] >= 4'h4 || op[3:0] == 4'h4 && op[7:4] >= 4'h2
                     && op[7:4] <= 4'h9 && op[7:4] != 4'h8 || op[3:0] == 4'h5 && op[7:4] != 4'hD
                     || op[7:4] == 4'h7 && op[3:2] != 2'h0 || op[7:4] == 4'h8 && op[3:1] >= 3'h3
                     || op[7:4] == 4'hA && op[3:1] >= 3'h3 || op[7:4] == 4'hD && op[3] ) begin
            // Two-byte forms: direct, immediate, bit and relative operands; divide is one byte
            d.len = LEN_2;
        end
        // Jumps, calls, returns, conditional branches and opcode 0x00 (NOP)
        if (op[3:0] == 4'h1 || op == 8'h02 || op == 8'h12 || op == 8'h22 || op == 8'h32 ||
            op == 8'h73 || op[3:0] == 4'h0 && op[7:4] <= 4'h8 || op == 8'hD5 ||
            op[7:4] == 4'hD && op[3] || op[7:4] == 4'hB && op[3:2] != 2'h0) begin
            d.branch = 1'b1;
            d.extra = EXTRA_BRANCH;
            d.mcyc = MC_MED;
        end
        // Multiply and divide
        if (op == 8'hA4 || op == 8'h84) begin
            d.extra = EXTRA_COMPLEX;
            d.mcyc = MC_LONG;
        end else if (op == 8'h83 || op == 8'h93 || op == 8'hA3 || op[7:4] >= 4'hE &&
                     op[3:0] <= 4'h3 && op[3:0] != 4'h1 || d.len == LEN_3) begin
            // Code reads, external data moves, increment of the data pointer (0xA3) and long forms
            if (!d.branch) begin
                d.extra = EXTRA_BRANCH;
            end
            d.mcyc = MC_MED;
        end
        return d;
    endfunction

    // Two-flop synchroniser on the fuse level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fuse_meta <= 1'b0;
            fuse_sync <= 1'b0;
        end else begin
            fuse_meta <= compat_fuse;
            fuse_sync <= fuse_meta;
        end
    end

    // Capture the fuse once after reset and hold it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_cnt <= 2'h0;
            mode <= MODE_RESET;
            mode_ready <= 1'b0;
        end else if (!mode_ready) begin
            init_cnt <= init_cnt + 2'h1;
            // Synchroniser holds the pin level from the third clock on
            if (init_cnt == 2'h2) begin
                mode <= (fuse_sync == FUSE_COMPAT) ? MODE_COMPAT : MODE_FAST;
                mode_ready <= 1'b1;
            end
        end
    end

    assign fast_mode = (mode == MODE_FAST);

    // Address above the internal array goes to external code
    assign code_external = ({1'b0, pc} >= INTERNAL_CODE_SIZE);

    // Fetch slot selection
    always_comb begin
        if (state != S_FETCH) begin
            slot = 1'b0;
        end else if (fast_mode && !code_external) begin
            slot = 1'b1;
        end else begin
            // Every third clock: compatibility, or fast from external code
            slot = (fetch_div == 2'h0);
        end
    end

    assign code_rd = slot && !redirect_valid;
    assign code_addr = pc;

    // Decode from the bus on the first byte, else from the held opcode
    assign dec_now = decode_op(code_data);
    assign dec_cur = decode_op(hold.opcode);
    assign dec_use = (byte_idx == 2'h0) ? dec_now : dec_cur;
    assign last_byte = code_rd && (byte_idx == dec_use.len - 2'h1);

    // Compatibility end point: whole machine cycles of twelve clocks
    assign mc_end = MC_CLK_W'(int'(dec_cur.mcyc) * OSC_PER_MC - 1);

    // Completion conditions per mode
    assign retire_fast = fast_mode && (last_byte && dec_use.extra == EXTRA_NONE ||
                         state == S_EXTRA && extra_cnt == 3'h1 && extra_slot);
    assign retire_compat = !fast_mode && state == S_ALIGN && instr_clk == mc_end;
    assign start = retire_compat || redirect_valid;

    // Extra slots keep the same pacing as fetches
    assign extra_slot = !code_external || fetch_div == 2'h0;

    // Fetch divider; restarts with each compatibility instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_div <= 2'h0;
        end else if (start || state == S_INIT) begin
            fetch_div <= 2'h0;
        end else if (fetch_div == 2'(COMPAT_FETCH_DIV - 1)) begin
            fetch_div <= 2'h0;
        end else begin
            fetch_div <= fetch_div + 2'h1;
        end
    end

    // Program counter advances on each fetched byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc <= RESET_PC;
        end else if (redirect_valid) begin
            pc <= redirect_addr;
        end else if (code_rd) begin
            pc <= pc + 1'b1;
        end
    end

    // Main sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_INIT;
            byte_idx <= 2'h0;
            extra_cnt <= 3'h0;
        end else begin
            unique case (state)
                S_INIT: begin
                    // Hold off fetching until the mode is known
                    if (mode_ready) begin
                        state <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (redirect_valid) begin
                        byte_idx <= 2'h0;
                    end else if (last_byte) begin
                        byte_idx <= 2'h0;
                        if (!fast_mode) begin
                            state <= S_ALIGN;
                        end else if (dec_use.extra != EXTRA_NONE) begin
                            extra_cnt <= dec_use.extra;
                            state <= S_EXTRA;
                        end
                    end else if (code_rd) begin
                        byte_idx <= byte_idx + 2'h1;
                    end
                end
                S_EXTRA: begin
                    // Target address or multi-cycle work
                    if (redirect_valid) begin
                        state <= S_FETCH;
                    end else if (extra_slot) begin
                        extra_cnt <= extra_cnt - 3'h1;
                        if (extra_cnt == 3'h1) begin
                            state <= S_FETCH;
                        end
                    end
                end
                S_ALIGN: begin
                    // Pad out to the machine-cycle boundary
                    if (start) begin
                        state <= S_FETCH;
                    end
                end
            endcase
        end
    end

    // Gather instruction bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold <= '0;
        end else if (code_rd) begin
            unique case (byte_idx)
                2'h0: begin
                    hold <= '0;
                    hold.opcode <= code_data;
                    hold.len <= dec_now.len;
                    hold.mcyc <= dec_now.mcyc;
                end
                2'h1: hold.op1 <= code_data;
                2'h2: hold.op2 <= code_data;
                default: hold <= hold;
            endcase
        end
    end

    // Issue to execute while the next fetch proceeds
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exec_valid <= 1'b0;
            exec_instr <= '0;
        end else begin
            exec_valid <= 1'b0;
            if (!redirect_valid && (retire_fast || retire_compat)) begin
                exec_valid <= 1'b1;
                exec_instr <= hold;
                // Last byte arrives in the same clock as a fast retire
                if (last_byte) begin
                    unique case (byte_idx)
                        2'h0: begin
                            exec_instr <= '0;
                            exec_instr.opcode <= code_data;
                            exec_instr.len <= dec_now.len;
                            exec_instr.mcyc <= dec_now.mcyc;
                        end
                        2'h1: exec_instr.op1 <= code_data;
                        2'h2: exec_instr.op2 <= code_data;
                        default: exec_instr <= hold;
                    endcase
                end
            end
        end
    end

    // Clock count since the instruction began
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_clk <= '0;
        end else if (start || state == S_INIT) begin
            instr_clk <= '0;
        end else begin
            instr_clk <= instr_clk + 1'b1;
        end
    end

    // Divide-by-two state clock and six-state machine cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half <= 1'b0;
            mc_state <= 3'h0;
        end else if (start || state == S_INIT) begin
            half <= 1'b0;
            mc_state <= 3'h0;
        end else begin
            half <= ~half;
            if (half) begin
                mc_state <= (mc_state == 3'(STATES_PER_MC - 1)) ? 3'h0 : mc_state + 3'h1;
            end
        end
    end

    // One-clock pulse at each state step in compatibility mode
    assign state_tick = !fast_mode && state != S_INIT && half;

endmodule

// File: verilog/fetch_timing_pkg.sv
// Shared constants and types for the fetch/execute timing block
package fetch_timing_pkg;

    // Operating mode chosen by the configuration fuse
    typedef enum logic {MODE_FAST, MODE_COMPAT} core_mode_t;

    // Mode held until the fuse is first sampled (factory default)
    localparam core_mode_t MODE_RESET = MODE_COMPAT;
    // Fuse level that selects compatibility timing
    localparam logic FUSE_COMPAT = 1'b1;

    // Clocks between byte fetches in compatibility mode
    localparam int COMPAT_FETCH_DIV = 3;
    // Slow-down factor for fast-mode fetches from external code
    localparam int EXT_FETCH_DIV = 3;
    // Oscillator periods and states per compatibility machine cycle
    localparam int OSC_PER_MC = 12;
    localparam int STATES_PER_MC = 6;
    // Width of a machine-cycle length in clocks
    localparam int MC_CLK_W = 6;

    // Extra fast-mode cycles per instruction class
    localparam logic [2:0] EXTRA_NONE = 3'h0;
    localparam logic [2:0] EXTRA_BRANCH = 3'h1;
    localparam logic [2:0] EXTRA_COMPLEX = 3'h2;

    // Machine cycles per instruction class in compatibility mode
    localparam logic [2:0] MC_SHORT = 3'h1;
    localparam logic [2:0] MC_MED = 3'h2;
    localparam logic [2:0] MC_LONG = 3'h4;

    // Instruction lengths in bytes
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;

    // Result of decoding a first byte
    typedef struct packed {
        logic [1:0] len;
        logic [2:0] extra;
        logic [2:0] mcyc;
        logic branch;
    } decode_t;

    // Instruction handed to the execute stage
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [1:0] len;
        logic [2:0] mcyc;
    } instr_t;

endpackage
